// [shared/issel_pkg.sv]
package issel_pkg;
  // Register map, byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_SPEED1   = 8'h00;
  localparam logic [7:0] ADDR_SPEED2   = 8'h04;
  localparam logic [7:0] ADDR_SPEED3   = 8'h08;
  localparam logic [7:0] ADDR_CONFIG   = 8'h0c;
  localparam logic [7:0] ADDR_MAXSPD   = 8'h10;
  localparam logic [7:0] ADDR_DECEL    = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_ACTIVE   = 8'h1c;

  localparam int SPEED_W = 14;
  localparam logic [13:0] SPEED_MAX_SET = 14'h2710;
  localparam logic [13:0] SPEED1_RST = 14'h0064;
  localparam logic [13:0] SPEED2_RST = 14'h00c8;
  localparam logic [13:0] SPEED3_RST = 14'h012c;
  localparam logic [13:0] MAXSPD_RST = 14'h2710;
  localparam logic [15:0] DECEL_RST  = 16'h0000;

  // Config field positions.
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_ALLOC_BIT  = 4;
  localparam int CFG_DD_BIT     = 5;
  localparam int CFG_CSEL_LSB   = 8;
  localparam int CFG_DIR_LSB    = 12;
  localparam int CFG_SPA_LSB    = 16;
  localparam int CFG_SPB_LSB    = 20;
  // Write-only strobe: never stored, so config reads show it as zero.
  localparam int CFG_RESTART_BIT = 7;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0003;
  localparam logic [31:0] CONFIG_MASK = 32'h00ff_ff3f;

  localparam logic [3:0] METHOD_ISS     = 4'h3;
  localparam logic [3:0] METHOD_ISS_SPD = 4'h4;
  localparam logic [3:0] METHOD_ISS_POS = 4'h5;
  localparam logic [3:0] METHOD_ISS_TRQ = 4'h6;

  // Timing: the input take-up must be no longer than 2 ms.
  localparam int CLK_HZ        = 50_000_000;
  localparam int TAKEUP_US     = 2000;
  localparam int TAKEUP_CYCLES = (CLK_HZ / 1_000_000) * TAKEUP_US;
  localparam int DECEL_MS_CYC  = CLK_HZ / 1000;

  typedef enum logic [3:0] {
    ISSEL_MODE_ISS = 4'b0001,
    ISSEL_MODE_SPD = 4'b0010,
    ISSEL_MODE_POS = 4'b0100,
    ISSEL_MODE_TRQ = 4'b1000
  } issel_mode_t;

  typedef enum logic [2:0] {
    ISSEL_ST_RUN   = 3'b001,
    ISSEL_ST_DECEL = 3'b010,
    ISSEL_ST_WAIT  = 3'b100
  } issel_state_t;
endpackage : issel_pkg

// [hdl/issel_route.sv]
`timescale 1ns/1ps
// Picks one terminal for each routed input by its allocation field.
module issel_route #(
  parameter int TERMS = 8,
  parameter int SEL_W = 3,
  parameter int LANES = 4
) (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  // Terminals and allocation
  input  wire logic [TERMS-1:0]       term_in,
  input  wire logic [LANES*SEL_W-1:0] alloc,
  // Routed signals, all from one sample
  output logic      [LANES-1:0]       routed_q
);
  logic [LANES-1:0] routed_d;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      routed_d[i] = term_in[alloc[i*SEL_W +: SEL_W]];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      routed_q <= '0;
    end else if (ce) begin
      routed_q <= routed_d;
    end
  end
endmodule : issel_route

// [hdl/issel_top.sv]
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module issel_top
  import issel_pkg::*;
#(
  parameter int TERMS = 8,
  parameter int DECEL_CYC_PER_MS = issel_pkg::DECEL_MS_CYC
) (
  // AHB-Lite clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Input terminals, high means contact closed
  input  wire logic                  fwd_limit_input,
  input  wire logic                  rev_limit_input,
  input  wire logic                  proportional_ctrl_input,
  input  wire logic [TERMS-1:0]      term_in,
  // Motor feedback
  input  wire logic                  motor_stopped,
  // Speed reference and mode out
  output logic [issel_pkg::SPEED_W-1:0] speed_ref_q,
  output logic                       reverse_q,
  output logic                       fine_unit_q,
  output issel_pkg::issel_mode_t     mode_q,
  output logic                       decel_q
);
  import issel_pkg::*;

  // Registers.
  logic [SPEED_W-1:0] speed1_q, speed1_d, speed2_q, speed2_d;
  logic [SPEED_W-1:0] speed3_q, speed3_d, maxspd_q, maxspd_d;
  logic [31:0]        config_q, config_d;
  logic [15:0]        decel_ms_q, decel_ms_d;
  logic [3:0]         method_q, method_d;
  logic               alloc_q, alloc_d;
  logic               restart_done_q, restart_done_d;
  // Bus data phase.
  logic               wr_q, wr_d, rd_q, rd_d;
  logic [7:0]         addr_q, addr_d;
  logic [31:0]        rdata_d;

  logic               accept;
  assign accept    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic [SPEED_W-1:0] clip(input logic [31:0] v);
    clip = (v > 32'(SPEED_MAX_SET)) ? SPEED_MAX_SET : v[SPEED_W-1:0];
  endfunction : clip

  always_comb begin
    wr_d     = accept & hwrite;
    rd_d     = accept & ~hwrite;
    addr_d   = accept ? haddr : addr_q;
    speed1_d = speed1_q;
    speed2_d = speed2_q;
    speed3_d = speed3_q;
    maxspd_d = maxspd_q;
    config_d = config_q;
    decel_ms_d = decel_ms_q;
    if (wr_q) begin
      case (addr_q)
        ADDR_SPEED1: speed1_d = clip(hwdata);
        ADDR_SPEED2: speed2_d = clip(hwdata);
        ADDR_SPEED3: speed3_d = clip(hwdata);
        ADDR_CONFIG: config_d = hwdata & CONFIG_MASK;
        ADDR_MAXSPD: maxspd_d = hwdata[SPEED_W-1:0];
        ADDR_DECEL:  decel_ms_d = hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Method and allocation latch after reset release, and again one cycle
  // after a config write with the restart bit set. The soft restart keeps
  // the stored settings, which reset alone would throw away.
  always_comb begin
    restart_done_d = ~(wr_q && (addr_q == ADDR_CONFIG) &&
                       hwdata[CFG_RESTART_BIT]);
    method_d = restart_done_q ? method_q :
               config_q[CFG_METHOD_LSB +: 4];
    alloc_d  = restart_done_q ? alloc_q : config_q[CFG_ALLOC_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      speed1_q <= SPEED1_RST;
      speed2_q <= SPEED2_RST;
      speed3_q <= SPEED3_RST;
      maxspd_q <= MAXSPD_RST;
      config_q <= CONFIG_RST;
      decel_ms_q <= DECEL_RST;
      method_q <= METHOD_ISS;
      alloc_q <= 1'b0;
      restart_done_q <= 1'b0;
    end else if (ce) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      speed1_q <= speed1_d;
      speed2_q <= speed2_d;
      speed3_q <= speed3_d;
      maxspd_q <= maxspd_d;
      config_q <= config_d;
      decel_ms_q <= decel_ms_d;
      method_q <= method_d;
      alloc_q <= alloc_d;
      restart_done_q <= restart_done_d;
    end
  end

  // Routed dedicated inputs: csel, direction, select low, select high.
  logic [3:0]  routed;
  logic [11:0] alloc_sel;
  assign alloc_sel = {config_q[CFG_SPB_LSB +: 3], config_q[CFG_SPA_LSB +: 3],
                      config_q[CFG_DIR_LSB +: 3], config_q[CFG_CSEL_LSB +: 3]};

  issel_route #(.TERMS(TERMS), .SEL_W(3), .LANES(4)) u_route (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .term_in  (term_in),
    .alloc    (alloc_sel),
    .routed_q (routed)
  );

  // Factory pins are sampled in the same cycle as the routed ones, so a
  // decode never mixes two samples.
  logic [2:0] fact_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fact_q <= 3'h0;
    end else if (ce) begin
      fact_q <= {rev_limit_input, fwd_limit_input,
                 proportional_ctrl_input};
    end
  end

  logic dir_in, sel_lo, sel_hi, csel;
  always_comb begin
    csel   = routed[0];
    dir_in = alloc_q ? routed[1] : fact_q[0];
    sel_lo = alloc_q ? routed[2] : fact_q[1];
    sel_hi = alloc_q ? routed[3] : fact_q[2];
  end

  // Decode: a one-cycle path keeps take-up far below the 2 ms bound.
  logic [SPEED_W-1:0] chosen, limited;
  logic               paired, want_partner;
  issel_mode_t        partner, target;
  always_comb begin
    case ({sel_lo, sel_hi})
      2'b00:   chosen = '0;
      2'b01:   chosen = speed1_q;
      2'b11:   chosen = speed2_q;
      2'b10:   chosen = speed3_q;
      default: chosen = '0;
    endcase
    limited = (chosen > maxspd_q) ? maxspd_q : chosen;
    paired = (method_q == METHOD_ISS_SPD) || (method_q == METHOD_ISS_POS) ||
             (method_q == METHOD_ISS_TRQ);
    case (method_q)
      METHOD_ISS_POS: partner = ISSEL_MODE_POS;
      METHOD_ISS_TRQ: partner = ISSEL_MODE_TRQ;
      default:        partner = ISSEL_MODE_SPD;
    endcase
    want_partner = alloc_q ? csel : ~(sel_lo | sel_hi);
    if (method_q == METHOD_ISS) begin
      target = ISSEL_MODE_ISS;
    end else if (paired && !want_partner) begin
      target = ISSEL_MODE_ISS;
    end else if (paired) begin
      target = partner;
    end else begin
      target = ISSEL_MODE_SPD;
    end
  end

  // Mode sequencer.
  issel_state_t st_q, st_d;
  issel_mode_t  mode_d;
  logic [15:0]  ms_q, ms_d;
  logic [31:0]  cyc_q, cyc_d;
  logic [SPEED_W-1:0] direction_select_input;
  logic         rev_d, dec_d;

  always_comb begin
    st_d   = st_q;
    mode_d = mode_q;
    ms_d   = ms_q;
    cyc_d  = cyc_q;
    direction_select_input  = (mode_q == ISSEL_MODE_ISS) ? limited : '0;
    rev_d  = dir_in;
    dec_d  = 1'b0;
    case (st_q)
      ISSEL_ST_RUN: begin
        if (mode_q == ISSEL_MODE_ISS && target == ISSEL_MODE_POS) begin
          st_d  = ISSEL_ST_DECEL;
          ms_d  = 16'h0000;
          cyc_d = 32'h0;
          direction_select_input = '0;
          dec_d = 1'b1;
        end else begin
          mode_d = target;
          direction_select_input  = (target == ISSEL_MODE_ISS) ? limited : '0;
        end
      end
      ISSEL_ST_DECEL: begin
        direction_select_input = '0;
        dec_d = 1'b1;
        if (target != ISSEL_MODE_POS) begin
          st_d   = ISSEL_ST_RUN;
          mode_d = target;
          direction_select_input  = (target == ISSEL_MODE_ISS) ? limited : '0;
          dec_d  = 1'b0;
        end else if (ms_q >= decel_ms_q) begin
          st_d = ISSEL_ST_WAIT;
        end else if (cyc_q == 32'(DECEL_CYC_PER_MS - 1)) begin
          cyc_d = 32'h0;
          ms_d  = ms_q + 16'h0001;
        end else begin
          cyc_d = cyc_q + 32'h1;
        end
      end
      ISSEL_ST_WAIT: begin
        direction_select_input = '0;
        dec_d = 1'b1;
        if (target != ISSEL_MODE_POS) begin
          st_d   = ISSEL_ST_RUN;
          mode_d = target;
          direction_select_input  = (target == ISSEL_MODE_ISS) ? limited : '0;
          dec_d  = 1'b0;
        end else if (motor_stopped) begin
          st_d   = ISSEL_ST_RUN;
          mode_d = ISSEL_MODE_POS;
          dec_d  = 1'b0;
        end
      end
      default: begin
        st_d   = ISSEL_ST_RUN;
        mode_d = ISSEL_MODE_ISS;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ISSEL_ST_RUN;
      mode_q <= ISSEL_MODE_ISS;
      ms_q <= 16'h0000;
      cyc_q <= 32'h0;
      speed_ref_q <= '0;
      reverse_q <= 1'b0;
      decel_q <= 1'b0;
      fine_unit_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      mode_q <= mode_d;
      ms_q <= ms_d;
      cyc_q <= cyc_d;
      speed_ref_q <= direction_select_input;
      reverse_q <= rev_d;
      decel_q <= dec_d;
      fine_unit_q <= config_q[CFG_DD_BIT];
    end
  end

  // Read data.
  always_comb begin
    rdata_d = 32'h0;
    case (addr_q)
      ADDR_SPEED1: rdata_d = 32'(speed1_q);
      ADDR_SPEED2: rdata_d = 32'(speed2_q);
      ADDR_SPEED3: rdata_d = 32'(speed3_q);
      ADDR_CONFIG: rdata_d = config_q;
      ADDR_MAXSPD: rdata_d = 32'(maxspd_q);
      ADDR_DECEL:  rdata_d = {16'h0000, decel_ms_q};
      ADDR_STATUS: rdata_d = {21'h0, st_q, routed, mode_q};
      ADDR_ACTIVE: rdata_d = {10'h0, alloc_q, method_q, 2'h0, reverse_q,
                              speed_ref_q};
      default:     rdata_d = 32'h0;
    endcase
    hrdata = rd_q ? rdata_d : 32'h0;
  end
endmodule : issel_top

// [verif/issel_top_props.sv]
`timescale 1ns/1ps
module issel_top_props
  import issel_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  // Pins and outputs
  input wire logic        fwd_limit_input,
  input wire logic        rev_limit_input,
  input wire logic        proportional_ctrl_input,
  input wire logic [13:0] speed_ref_q,
  input wire logic        reverse_q,
  input wire issel_mode_t mode_q,
  input wire logic        decel_q,
  input wire logic        motor_stopped
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A pin sample reaches the outputs two edges later.
  sequence s_sel_off;
    !fwd_limit_input && !rev_limit_input ##2 1'b1;
  endsequence
  sequence s_sel_on;
    (fwd_limit_input || rev_limit_input) ##2 1'b1;
  endsequence
  sequence s_dir_on;
    proportional_ctrl_input ##2 1'b1;
  endsequence
  sequence s_dir_off;
    !proportional_ctrl_input ##2 1'b1;
  endsequence
  // From set speed control, position is entered straight from the deceleration wait.
  sequence s_pos_entry;
    decel_q ##1 (mode_q == ISSEL_MODE_POS);
  endsequence
  a_zero_speed: assert property (s_sel_off |-> speed_ref_q == 14'h0000)
    else $error("speed not zero with both selects off");
  // A select only forces a speed while set speed control runs.
  a_sel_speed: assert property (s_sel_on |->
    mode_q != ISSEL_MODE_ISS || speed_ref_q != 14'h0000)
    else $error("speed zero with a select on");
  a_dir_rev: assert property (s_dir_on |-> reverse_q)
    else $error("direction on did not run reverse");
  a_dir_fwd: assert property (s_dir_off |-> !reverse_q)
    else $error("direction off did not run forward");
  a_speed_cap: assert property (speed_ref_q <= SPEED_MAX_SET)
    else $error("speed above settable range");
  a_mode_onehot: assert property ($onehot(mode_q))
    else $error("mode output not one hot");
  a_decel_zero: assert property (decel_q |-> speed_ref_q == 14'h0000)
    else $error("speed reference not zero while decelerating");
  a_stop_entry: assert property (s_pos_entry |-> $past(motor_stopped))
    else $error("position entered before the motor stopped");
  a_read_zero: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside a read phase");
endmodule : issel_top_props

bind issel_top issel_top_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
  .fwd_limit_input(fwd_limit_input), .rev_limit_input(rev_limit_input),
  .proportional_ctrl_input(proportional_ctrl_input),
  .speed_ref_q(speed_ref_q), .reverse_q(reverse_q), .mode_q(mode_q),
  .decel_q(decel_q), .motor_stopped(motor_stopped)
);

// [verif/issel_switches.sv]
`timescale 1ns/1ps
// Host contacts; high means closed, and they move only on a clock edge.
module issel_switches (
  // Clock
  input wire logic hclk,
  // Commanded contact states
  input wire logic dir_cmd,
  input wire logic lo_cmd,
  input wire logic hi_cmd,
  input wire logic [7:0] term_cmd,
  // Contact outputs
  output logic     proportional_ctrl_input,
  output logic     fwd_limit_input,
  output logic     rev_limit_input,
  output logic [7:0] term_in
);
  always @(posedge hclk) begin
    proportional_ctrl_input <= dir_cmd;
    fwd_limit_input         <= lo_cmd;
    rev_limit_input         <= hi_cmd;
    term_in                 <= term_cmd;
  end
endmodule : issel_switches

// [verif/issel_top_tb.sv]
`timescale 1ns/1ps
module issel_top_tb;
  import issel_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic        dir_cmd = 1'b0, lo_cmd = 1'b0, hi_cmd = 1'b0;
  logic        motor_stopped = 1'b1;
  logic [7:0]  term_cmd = 8'h00, t_in;
  localparam logic [31:0] RESTART = 32'h1 << CFG_RESTART_BIT;
  // Changed allocation: method 4, csel on terminal 0, then 1, 2 and 3.
  localparam logic [31:0] ALLOC_CFG = 32'(METHOD_ISS_SPD) |
    (32'h1 << CFG_ALLOC_BIT) | (32'h1 << CFG_DIR_LSB) |
    (32'h2 << CFG_SPA_LSB) | (32'h3 << CFG_SPB_LSB);
  logic        hreadyout, hresp, pc_in, fl_in, rl_in, reverse_q, fine_unit_q;
  logic        decel_q;
  logic [13:0] speed_ref_q;
  issel_mode_t mode_q;
  int          n_errors = 0, check_count = 0;

  always #10 hclk = ~hclk;

  issel_switches u_sw (.hclk(hclk), .dir_cmd(dir_cmd), .lo_cmd(lo_cmd),
    .hi_cmd(hi_cmd), .term_cmd(term_cmd), .proportional_ctrl_input(pc_in),
    .fwd_limit_input(fl_in), .rev_limit_input(rl_in), .term_in(t_in));

  // Decel count shortened so a position entry would stay quick in sim.
  issel_top #(.DECEL_CYC_PER_MS(2)) DUT (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fwd_limit_input(fl_in), .rev_limit_input(rl_in),
    .proportional_ctrl_input(pc_in), .term_in(t_in),
    .motor_stopped(motor_stopped), .speed_ref_q(speed_ref_q),
    .reverse_q(reverse_q), .fine_unit_q(fine_unit_q), .mode_q(mode_q),
    .decel_q(decel_q));

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Looks just before the edge, so the edge sees the same hready.
  task wait_ready;
    int k;
    k = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && k < 50) begin
      k++;
      @(negedge hclk);
    end
    if (k == 50) n_errors++;
  endtask : wait_ready

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    wait_ready();
    @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    wait_ready();
    rd = hrdata;
    @(posedge hclk);
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task pins(input logic [2:0] v, input logic [7:0] t);
    @(posedge hclk);
    {dir_cmd, lo_cmd, hi_cmd} <= v;
    term_cmd <= t;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask : pins

  task t_regs;
    logic [31:0] d;
    bus(1'b0, ADDR_SPEED1, 32'h0, d); chk("speed1", d, 32'(SPEED1_RST));
    bus(1'b0, ADDR_SPEED2, 32'h0, d); chk("speed2", d, 32'(SPEED2_RST));
    bus(1'b0, ADDR_SPEED3, 32'h0, d); chk("speed3", d, 32'(SPEED3_RST));
    bus(1'b0, ADDR_CONFIG, 32'h0, d); chk("config", d, CONFIG_RST);
    chk("mode", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    chk("hreadyout", 32'(hreadyout), 32'h1);
    chk("hresp", 32'(hresp), 32'h0);
    $display("test regs done");
  endtask : t_regs

  task t_clip;
    logic [31:0] d;
    wr(ADDR_SPEED1, 32'h0000_3000);
    bus(1'b0, ADDR_SPEED1, 32'h0, d); chk("clip", d, 32'h0000_2710);
    bus(1'b0, 8'h40, 32'h0, d); chk("unmapped", d, 32'h0);
    wr(ADDR_SPEED1, 32'(SPEED1_RST));
    $display("test clip done");
  endtask : t_clip

  task t_decode;
    logic [13:0] e;
    for (int i = 0; i < 8; i++) begin
      pins(3'(i), 8'h00);
      case (i % 4)
        0: e = 14'h0000;
        1: e = SPEED1_RST;
        3: e = SPEED2_RST;
        default: e = SPEED3_RST;
      endcase
      chk("speed", 32'(speed_ref_q), 32'(e));
      chk("reverse", 32'(reverse_q), 32'(i / 4));
    end
    $display("test decode done");
  endtask : t_decode

  task t_limits;
    wr(ADDR_MAXSPD, 32'd150);
    pins(3'b011, 8'h00);
    chk("capped", 32'(speed_ref_q), 32'd150);
    wr(ADDR_MAXSPD, 32'h0000_2710);
    wr(ADDR_SPEED3, 32'd555);
    pins(3'b110, 8'h00);
    chk("speed3 new", 32'(speed_ref_q), 32'd555);
    chk("reverse", 32'(reverse_q), 32'h1);
    wr(ADDR_CONFIG, 32'h0000_0023);
    repeat (2) @(negedge hclk);
    chk("fine unit", 32'(fine_unit_q), 32'h1);
    chk("mode kept", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    $display("test limits done");
  endtask : t_limits

  task t_pair;
    issel_mode_t e;
    for (int c = 4; c < 7; c++) begin
      wr(ADDR_CONFIG, 32'(c) | RESTART);
      pins(3'b000, 8'h00);
      repeat (3) @(negedge hclk);
      case (c)
        4: e = ISSEL_MODE_SPD;
        5: e = ISSEL_MODE_POS;
        default: e = ISSEL_MODE_TRQ;
      endcase
      chk("partner", 32'(mode_q), 32'(e));
      chk("partner speed", 32'(speed_ref_q), 32'h0);
      pins(3'b001, 8'h00);
      chk("back to set", 32'(mode_q), 32'(ISSEL_MODE_ISS));
      chk("set speed1", 32'(speed_ref_q), 32'(SPEED1_RST));
    end
    $display("test pair done");
  endtask : t_pair

  task t_decel;
    wr(ADDR_DECEL, 32'd3);
    wr(ADDR_CONFIG, 32'(METHOD_ISS_POS) | RESTART);
    motor_stopped <= 1'b0;
    pins(3'b000, 8'h00);
    chk("decel", 32'(decel_q), 32'h1);
    chk("decel speed", 32'(speed_ref_q), 32'h0);
    chk("still set", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    repeat (20) @(negedge hclk);
    chk("wait stop", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    @(posedge hclk);
    motor_stopped <= 1'b1;
    repeat (3) @(negedge hclk);
    chk("position", 32'(mode_q), 32'(ISSEL_MODE_POS));
    chk("decel end", 32'(decel_q), 32'h0);
    motor_stopped <= 1'b0;
    pins(3'b010, 8'h00);
    chk("set again", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    chk("speed3 again", 32'(speed_ref_q), 32'd555);
    $display("test decel done");
  endtask : t_decel

  // Factory pins mirror the routed terminals so the pin checker stays valid.
  task t_alloc;
    logic [31:0] d;
    pins(3'b111, 8'h0f);
    wr(ADDR_CONFIG, ALLOC_CFG | RESTART);
    repeat (3) @(negedge hclk);
    chk("csel closed", 32'(mode_q), 32'(ISSEL_MODE_SPD));
    bus(1'b0, ADDR_STATUS, 32'h0, d);
    chk("routed", d, {21'h0, ISSEL_ST_RUN, 4'hf, ISSEL_MODE_SPD});
    pins(3'b110, 8'h06);
    chk("csel open", 32'(mode_q), 32'(ISSEL_MODE_ISS));
    chk("routed speed", 32'(speed_ref_q), 32'd555);
    chk("routed dir", 32'(reverse_q), 32'h1);
    $display("test alloc done");
  endtask : t_alloc

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_clip();
    t_decode();
    t_limits();
    t_pair();
    t_decel();
    t_alloc();
    end_of_test();
  end

  initial begin
    #200us;
    n_errors++;
    end_of_test();
  end
endmodule : issel_top_tb
